/* File: rtl/pir_line_sync.sv */
package pir_pkg;
    // ======================================================================
    // Register map and field layout
    // ======================================================================
    localparam int          PIR_LINES       = 4;
    localparam int          PIR_ISA_LEVELS  = 16;
    localparam int          PIR_DATA_W      = 8;
    localparam int          PIR_NIB_W       = 4;
    localparam int          PIR_ADDR_W      = 2;
    // Only address bit 0 is decoded, so offsets 2 and 3 alias 0 and 1.
    localparam int          PIR_REG_SEL_BIT = 0;
    localparam logic        PIR_OFF_AB      = 1'h0;
    localparam logic        PIR_OFF_CD      = 1'h1;
    localparam int          PIR_LO_NIB_LSB  = 0;
    localparam int          PIR_HI_NIB_LSB  = 4;
    localparam logic [7:0]  PIR_CTRL_RST    = 8'h00;
    localparam logic [3:0]  PIR_PASS_CODE   = 4'h0;
    localparam int          PIR_ADV_PCI_BASE = 16;
    localparam int          PIR_SYNC_STAGES = 3;
endpackage : pir_pkg

`timescale 1ns/1ps

module pir_line_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // Pin side
    input  wire logic [WIDTH-1:0] async_i,
    // Filtered level
    output logic      [WIDTH-1:0] level_o
);
    import pir_pkg::*;

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge clk_i) begin
        stage1_ff <= async_i;
        stage2_ff <= stage1_ff;
        stage3_ff <= stage2_ff;
    end

    // A pin level is accepted once the second and third stages agree.
    // The pins idle high, so the filtered level resets high.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    level_ff[gi] <= 1'b1;
                end else if (stage2_ff[gi] == stage3_ff[gi]) begin
                    level_ff[gi] <= stage3_ff[gi];
                end
            end
        end
    endgenerate

    assign level_o = level_ff;
endmodule : pir_line_sync

/* File: rtl/pir_rerouter.sv */
// What this block does
// - A pass-through line drives its own advanced controller input among 16-19.
// - Each line may be steered alone onto a chosen legacy IRQ level.
// - Two 8-bit routing registers, one nibble steering each PCI line.
// - Only two byte addresses are used; the other two in the window alias.
// - Lines A to D map in order onto advanced inputs 16 to 19.
// - Legacy levels 0-15 feed advanced inputs 0-15; only levels 1-15 carry rerouted requests.
`timescale 1ns/1ps

module pir_rerouter
    import pir_pkg::*;
(
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              reset_i,
    // Programmed I/O port from the host bridge
    input  wire logic                              cs_n_i,
    input  wire logic [pir_pkg::PIR_ADDR_W-1:0]    addr_i,
    input  wire logic                              wr_i,
    input  wire logic                              rd_i,
    input  wire logic [pir_pkg::PIR_DATA_W-1:0]    wdata_i,
    output logic      [pir_pkg::PIR_DATA_W-1:0]    rdata_o,
    // Shared PCI interrupt pins, active low
    input  wire logic                              pci_irq_line_a_n_i,
    input  wire logic                              pci_irq_line_b_n_i,
    input  wire logic                              pci_irq_line_c_n_i,
    input  wire logic                              pci_irq_line_d_n_i,
    // Dedicated advanced controller inputs 16-19, active low
    output logic      [pir_pkg::PIR_LINES-1:0]     adv_irq_pci_n_o,
    // Legacy IRQ levels 0-15, active high
    output logic      [pir_pkg::PIR_ISA_LEVELS-1:0] isa_irq_o
);
    import pir_pkg::*;

    // ======================================================================
    // Register file
    // ======================================================================
    logic [PIR_DATA_W-1:0] reroute_ctrl_lines_ab_ff;
    logic [PIR_DATA_W-1:0] reroute_ctrl_lines_cd_ff;
    logic [PIR_DATA_W-1:0] rdata_ff;
    logic                  sel_cd;
    logic                  wr_hit;
    logic                  rd_hit;

    assign wr_hit = !cs_n_i && wr_i;
    assign rd_hit = !cs_n_i && rd_i;
    assign sel_cd = addr_i[PIR_REG_SEL_BIT];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reroute_ctrl_lines_ab_ff <= PIR_CTRL_RST;
            reroute_ctrl_lines_cd_ff <= PIR_CTRL_RST;
        end else if (wr_hit) begin
            if (sel_cd == PIR_OFF_CD) begin
                reroute_ctrl_lines_cd_ff <= wdata_i;
            end else begin
                reroute_ctrl_lines_ab_ff <= wdata_i;
            end
        end
    end

    // A read in the same cycle as a write returns the value before the write.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= '0;
        end else if (rd_hit) begin
            rdata_ff <= (sel_cd == PIR_OFF_CD) ? reroute_ctrl_lines_cd_ff
                                               : reroute_ctrl_lines_ab_ff;
        end
    end

    assign rdata_o = rdata_ff;

    // ======================================================================
    // Pin synchronisation
    // ======================================================================
    logic [PIR_LINES-1:0] pin_level;
    logic [PIR_LINES-1:0] line_act;

    pir_line_sync #(
        .WIDTH   (PIR_LINES)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i ({pci_irq_line_d_n_i, pci_irq_line_c_n_i,
                   pci_irq_line_b_n_i, pci_irq_line_a_n_i}),
        .level_o (pin_level)
    );

    assign line_act = ~pin_level;

    // ======================================================================
    // Steering
    // ======================================================================
    logic [PIR_NIB_W-1:0]      line_code [PIR_LINES];
    logic [PIR_ISA_LEVELS-1:0] line_onehot [PIR_LINES];
    logic [PIR_LINES-1:0]      nxt_adv_n;
    logic [PIR_ISA_LEVELS-1:0] nxt_isa;
    logic [PIR_LINES-1:0]      adv_n_ff;
    logic [PIR_ISA_LEVELS-1:0] isa_ff;

    // line order A, B in one register and C, D in the other.
    assign line_code[0] = reroute_ctrl_lines_ab_ff[PIR_LO_NIB_LSB +: PIR_NIB_W];
    assign line_code[1] = reroute_ctrl_lines_ab_ff[PIR_HI_NIB_LSB +: PIR_NIB_W];
    assign line_code[2] = reroute_ctrl_lines_cd_ff[PIR_LO_NIB_LSB +: PIR_NIB_W];
    assign line_code[3] = reroute_ctrl_lines_cd_ff[PIR_HI_NIB_LSB +: PIR_NIB_W];

    // Code zero is pass-through, so legacy level 0 can never be chosen as a target.
    genvar gl;
    generate
        for (gl = 0; gl < PIR_LINES; gl++) begin : g_line
            assign nxt_adv_n[gl] = !(line_act[gl] && line_code[gl] == PIR_PASS_CODE);
            // each line steered on its own code.
            always_comb begin
                line_onehot[gl] = '0;
                if (line_act[gl] && line_code[gl] != PIR_PASS_CODE) begin
                    line_onehot[gl][line_code[gl]] = 1'b1;
                end
            end
        end
    endgenerate

    // shared legacy levels are the OR of every line steered there.
    always_comb begin
        nxt_isa = '0;
        for (int i = 0; i < PIR_LINES; i++) begin
            nxt_isa = nxt_isa | line_onehot[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            adv_n_ff <= '1;
            isa_ff   <= '0;
        end else begin
            adv_n_ff <= nxt_adv_n;
            isa_ff   <= nxt_isa;
        end
    end

    assign adv_irq_pci_n_o = adv_n_ff;
    assign isa_irq_o       = isa_ff;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Reset masks every check; a_reset_idle looks at the first edge after release.

    a_pass_forward: assert property (
        line_act[0] && line_code[0] == PIR_PASS_CODE |=> !adv_irq_pci_n_o[0])
        else $error("Pass-through line A not forwarded.");
    a_reroute_level: assert property (
        line_act[1] && line_code[1] != PIR_PASS_CODE |=> isa_irq_o[$past(line_code[1])])
        else $error("Rerouted line B missing on its legacy level.");
    a_reg_write: assert property (
        wr_hit && addr_i == 2'h1 |=> reroute_ctrl_lines_cd_ff == $past(wdata_i))
        else $error("Write to second routing register lost.");
    a_alias_write: assert property (
        wr_hit && addr_i == 2'h2 |=> reroute_ctrl_lines_ab_ff == $past(wdata_i)
            && $stable(reroute_ctrl_lines_cd_ff))
        else $error("Aliased address did not reach first register.");
    a_line_order: assert property (
        line_act[3] && line_code[3] == PIR_PASS_CODE && !line_act[2]
            |=> !adv_irq_pci_n_o[3] && adv_irq_pci_n_o[2])
        else $error("Line D not on its own advanced input.");
    a_legacy_quiet: assert property (
        (line_code[0] == PIR_PASS_CODE || !line_act[0])
            && (line_code[1] == PIR_PASS_CODE || !line_act[1])
            && (line_code[2] == PIR_PASS_CODE || !line_act[2])
            && (line_code[3] == PIR_PASS_CODE || !line_act[3])
            |=> isa_irq_o == '0)
        else $error("Legacy level raised with no rerouted request.");
    a_reroute_mask: assert property (
        line_code[2] != PIR_PASS_CODE |=> adv_irq_pci_n_o[2])
        else $error("Rerouted line C leaked to its dedicated input.");
    a_ab_write: assert property (
        wr_hit && addr_i == 2'h0 |=> reroute_ctrl_lines_ab_ff == $past(wdata_i)
            && $stable(reroute_ctrl_lines_cd_ff))
        else $error("Write to first routing register lost.");
    a_read_back: assert property (
        rd_hit |=> rdata_o == ($past(sel_cd) == PIR_OFF_CD
                                ? $past(reroute_ctrl_lines_cd_ff)
                                : $past(reroute_ctrl_lines_ab_ff)))
        else $error("Read data does not match the addressed register.");
    a_no_select: assert property (
        cs_n_i |=> $stable(reroute_ctrl_lines_ab_ff) && $stable(reroute_ctrl_lines_cd_ff))
        else $error("Routing register changed without chip select.");
    a_reset_idle: assert property (
        $fell(reset_i) |-> adv_irq_pci_n_o == '1 && isa_irq_o == '0 && rdata_o == '0
            && reroute_ctrl_lines_ab_ff == PIR_CTRL_RST
            && reroute_ctrl_lines_cd_ff == PIR_CTRL_RST)
        else $error("Outputs or routing left non-idle by reset.");

    genvar ga;
    generate
        for (ga = 0; ga < PIR_LINES; ga++) begin : g_line_chk
            a_line_pass: assert property (
                line_act[ga] && line_code[ga] == PIR_PASS_CODE |=> !adv_irq_pci_n_o[ga])
                else $error("Pass-through line not forwarded to its dedicated input.");
            a_line_level: assert property (
                line_act[ga] && line_code[ga] != PIR_PASS_CODE
                    |=> isa_irq_o[$past(line_code[ga])])
                else $error("Rerouted line missing on its legacy level.");
            a_line_mask: assert property (
                line_code[ga] != PIR_PASS_CODE |=> adv_irq_pci_n_o[ga])
                else $error("Rerouted line leaked to its dedicated input.");
        end
    endgenerate


    c_reroute_a: cover property (line_act[0] && line_code[0] != PIR_PASS_CODE ##1 isa_ff != '0);
    c_alias_rd: cover property (rd_hit && addr_i == 2'h3);
    c_shared_level: cover property (line_act[0] && line_act[1] && line_code[0] == line_code[1]
                                    && line_code[0] != PIR_PASS_CODE);
    c_pass_d: cover property (line_act[3] && line_code[3] == PIR_PASS_CODE ##1 !adv_n_ff[3]);
    c_no_select: cover property (cs_n_i && wr_i);
endmodule : pir_rerouter

/* File: tb/pir_host_model.sv */
`timescale 1ns/1ps

module pir_host_model
    import pir_pkg::*;
(
    // Clock
    input  wire logic                           clk_i,
    // Programmed I/O port
    output logic                                cs_n_o,
    output logic [pir_pkg::PIR_ADDR_W-1:0]      addr_o,
    output logic                                wr_o,
    output logic                                rd_o,
    output logic [pir_pkg::PIR_DATA_W-1:0]      wdata_o,
    input  wire logic [pir_pkg::PIR_DATA_W-1:0] rdata_i
);
    initial begin
        cs_n_o  = 1'b1;
        addr_o  = 2'h0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end

    // ======================================================================
    // One decoded access
    // ======================================================================
    // decoded chip select
    task automatic access(input logic [1:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_i);
        cs_n_o  <= 1'b0;
        addr_o  <= a;
        wr_o    <= w;
        rd_o    <= !w;
        wdata_o <= d;
        @(posedge clk_i);
        cs_n_o  <= 1'b1;
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
    endtask : access

    task automatic unselected_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cs_n_o  <= 1'b1;
        addr_o  <= a;
        wr_o    <= 1'b1;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : unselected_write
endmodule : pir_host_model

/* File: tb/test_pir_rerouter.sv */
`timescale 1ns/1ps

module test_pir_rerouter;
    import pir_pkg::*;
    logic        clk_i;
    logic        reset_i;
    logic        cs_n;
    logic        wr;
    logic        rd;
    logic [1:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  q;
    logic [3:0]  pin_n;
    logic [3:0]  adv_n;
    logic [15:0] isa;
    int          n_errors = 0;
    int          n_compared = 0;

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    pir_rerouter pir_rerouter_i (
        .clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .addr_i(addr), .wr_i(wr),
        .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .pci_irq_line_a_n_i(pin_n[0]),
        .pci_irq_line_b_n_i(pin_n[1]), .pci_irq_line_c_n_i(pin_n[2]),
        .pci_irq_line_d_n_i(pin_n[3]), .adv_irq_pci_n_o(adv_n), .isa_irq_o(isa));
    pir_host_model pir_host_model_i (
        .clk_i(clk_i), .cs_n_o(cs_n), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata));

    // ======================================================================
    // Helpers
    // ======================================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // Pins pass a synchronizer, so give each change six edges to show.
    task automatic pins(input logic [3:0] v);
        @(posedge clk_i);
        pin_n <= v;
        repeat (6) @(posedge clk_i);
        #1;
    endtask : pins

    initial begin
        #(25ns * 4000);
        n_errors++;
        end_sim();
    end

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        reset_i = 1'b1;
        pin_n   = 4'hf;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        check(adv_n, 4'hf);
        check(isa, 16'h0000);
        pir_host_model_i.access(2'h0, 1'b0, 8'h00, q);
        check(q, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pins(~(4'h1 << i));
            check(adv_n, 4'(~(4'h1 << i)));
            check(isa, 16'h0000);
            pins(4'hf);
        end
        for (int c = 1; c < 16; c++) begin
            pir_host_model_i.access(2'h0, 1'b1, 8'(c), q);
            pins(4'he);
            check(isa, 16'h1 << c);
            check(adv_n, 4'hf);
            pins(4'hf);
        end
        pir_host_model_i.access(2'h2, 1'b1, 8'h35, q);
        pir_host_model_i.access(2'h3, 1'b1, 8'hf7, q);
        pir_host_model_i.access(2'h1, 1'b0, 8'h00, q);
        check(q, 8'hf7);
        pir_host_model_i.unselected_write(2'h1, 8'h5a);
        pir_host_model_i.access(2'h3, 1'b0, 8'h00, q);
        check(q, 8'hf7);
        pir_host_model_i.access(2'h0, 1'b0, 8'h00, q);
        check(q, 8'h35);
        pins(4'h0);
        check(adv_n, 4'hf);
        check(isa, 16'h80a8);
        pir_host_model_i.access(2'h1, 1'b1, 8'h00, q);
        repeat (3) @(posedge clk_i);
        #1;
        check(adv_n, 4'h3);
        check(isa, 16'h0028);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        pir_host_model_i.access(2'h0, 1'b0, 8'h00, q);
        check(q, 8'h00);
        check(adv_n, 4'h0);
        check(isa, 16'h0000);
        end_sim();
    end
endmodule : test_pir_rerouter
